/* dv/cmh_asserts.sv */
// Checker on the message object handler ports, bound into the handler
`timescale 1ns/100ps
module cmh_asserts
   import cmh_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // APB side
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Protocol engine side
   input wire logic i_tx_ready,
   input wire logic i_tx_done,
   input wire logic i_tx_fail,
   input wire logic o_tx_load,
   input wire cmh_frame_type o_tx_frame
);
   logic busy_r; // Frame in flight between load and its outcome
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   // Track one frame in flight so a second load is caught
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         busy_r <= 1'b0;
      else if (o_tx_load)
         busy_r <= 1'b1;
      else if (i_tx_done || i_tx_fail)
         busy_r <= 1'b0;
   end
   setup_ready_a: assert property (i_psel && !i_penable |=> o_pready)
      else $error("No ready after setup");
   access_ready_a: assert property (o_pready |-> i_psel && i_penable)
      else $error("Ready outside access");
   ready_once_a: assert property (o_pready |=> !o_pready)
      else $error("Ready longer than one cycle");
   err_qual_a: assert property (o_pslverr |-> o_pready)
      else $error("Error without ready");
   load_pulse_a: assert property (o_tx_load |=> !o_tx_load)
      else $error("Load longer than one cycle");
   load_ready_a: assert property (o_tx_load |-> $past(i_tx_ready))
      else $error("Load while shifter not ready");
   load_once_a: assert property (o_tx_load |-> !busy_r)
      else $error("Load before outcome of last frame");
   frame_hold_a: assert property (!o_tx_load |-> $stable(o_tx_frame))
      else $error("Frame changed without load");
   // Main scenarios reached
   cover property (o_tx_load);
   cover property (i_tx_fail ##[1:200] o_tx_load);
   cover property (o_pslverr);
endmodule

bind cmh_handler cmh_asserts i_cmh_asserts (.i_mclk, .i_reset_n, .i_psel, .i_penable,
   .o_pready, .o_pslverr, .i_tx_ready, .i_tx_done, .i_tx_fail, .o_tx_load, .o_tx_frame);

/* dv/cmh_handler_tb_top.sv */
// Self-checking bench for the message object handler
`timescale 1ns/100ps
module cmh_handler_tb_top
   import cmh_pkg::*;
;
   localparam logic [11:0] S2 = CMH_IF_STRIDE; // Second interface set
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en = 1'b0, fail_next = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic pready, pslverr, err, tx_ready, tx_done, tx_fail, tx_load, rx_hdr, rx_end;
   cmh_frame_type tx_frame, rx_frame;
   int failures = 0, n_compared = 0, cyc = 0;
   always #25 i_mclk = ~i_mclk;
   cmh_handler i_cmh_handler (.i_mclk, .i_reset_n, .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_tx_ready(tx_ready), .i_tx_done(tx_done),
      .i_tx_fail(tx_fail), .o_tx_load(tx_load), .o_tx_frame(tx_frame),
      .i_rx_hdr_valid(rx_hdr), .i_rx_end(rx_end), .i_rx_frame(rx_frame));
   cmh_partner i_cmh_partner (.i_mclk, .i_reset_n, .i_en(en), .i_fail_next(fail_next),
      .i_tx_load(tx_load), .o_tx_ready(tx_ready), .o_tx_done(tx_done), .o_tx_fail(tx_fail),
      .o_rx_hdr_valid(rx_hdr), .o_rx_end(rx_end), .o_rx_frame(rx_frame));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge i_mclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_mclk);
   endtask
   // Command mask then object number, then wait for busy to clear
   task automatic xfer(input logic [11:0] s, input logic [5:0] obj, input logic [7:0] cm);
      apb(1'b1, s + CMH_OFS_CMSK, {24'h0, cm});
      apb(1'b1, s + CMH_OFS_CRQ, {26'h0, obj});
      do
      begin
         apb(1'b0, s + CMH_OFS_CRQ, 32'h0);
      end
      while (rd[CMH_CRQ_BUSY] !== 1'b0);
   endtask
   // Whole object written, data words before any request bit
   task automatic cfg(input logic [11:0] s, input logic [5:0] obj, input logic [31:0] arb,
      input logic [31:0] ctl, input logic [31:0] dlo);
      apb(1'b1, s + CMH_OFS_MSK, 32'h0);
      apb(1'b1, s + CMH_OFS_ARB, arb);
      apb(1'b1, s + CMH_OFS_DLO, dlo);
      apb(1'b1, s + CMH_OFS_DHI, 32'h0);
      apb(1'b1, s + CMH_OFS_MCTL, ctl);
      xfer(s, obj, 8'hF3);
   endtask
   // Wait for a load and compare the identifier sent
   task automatic wait_load(input logic [28:0] id);
      do
      begin
         @(posedge i_mclk);
      end
      while (tx_load !== 1'b1);
      chk({3'h0, tx_frame.id}, {3'h0, id});
   endtask
   // Retry after failure, with a lower-numbered object requested meanwhile
   task automatic t_prio();
      cfg(12'h000, 6'h03, 32'hE000_0333, 32'h0000_0038, 32'h3);
      cfg(12'h000, 6'h02, 32'hE000_0222, 32'h0000_1138, 32'h2);
      apb(1'b0, CMH_OFS_FRESH, 32'h0);
      chk(rd & 32'h6, 32'h2);
      fail_next <= 1'b1;
      en <= 1'b1;
      wait_load(29'h222);
      fail_next <= 1'b0;
      cfg(12'h000, 6'h01, 32'hE000_0111, 32'h0000_0038, 32'h1);
      wait_load(29'h111);
      wait_load(29'h222);
      wait_load(29'h333);
      repeat (50) @(posedge i_mclk);
      apb(1'b0, CMH_OFS_FRESH, 32'h0);
      chk(rd & 32'h6, 32'h0);
      apb(1'b0, CMH_OFS_TXRQ, 32'h0);
      chk(rd & 32'h7, 32'h0);
      apb(1'b0, CMH_OFS_PEND, 32'h0);
      chk(rd & 32'h7, 32'h2);
      apb(1'b0, CMH_OFS_INTID, 32'h0);
      chk(rd, 32'h2);
      xfer(12'h000, 6'h02, 8'h08);
   endtask
   // Two data frames into one object through the second set
   task automatic t_rx();
      cfg(S2, 6'h05, 32'hC000_5555, 32'h0000_0098, 32'h0);
      cfg(S2, 6'h09, 32'hC000_5555, 32'h0000_0098, 32'h0);
      i_cmh_partner.rx_send({1'b1, 1'b0, 29'h5555, 4'h8, 64'h1111_2222_3333_4444});
      i_cmh_partner.rx_send({1'b1, 1'b0, 29'h5555, 4'h8, 64'hAAAA_BBBB_CCCC_DDDD});
      apb(1'b0, CMH_OFS_FRESH, 32'h0);
      chk(rd & 32'h110, 32'h10);
      xfer(S2, 6'h05, 8'h73);
      apb(1'b0, S2 + CMH_OFS_MCTL, 32'h0);
      chk(rd & 32'h1C0F, 32'h1C08);
      apb(1'b0, S2 + CMH_OFS_DLO, 32'h0);
      chk(rd, 32'hCCCC_DDDD);
      apb(1'b0, CMH_OFS_INTID, 32'h0);
      chk(rd, 32'h5);
      xfer(S2, 6'h05, 8'h04);
      apb(1'b0, CMH_OFS_FRESH, 32'h0);
      chk(rd & 32'h10, 32'h0);
   endtask
   // Remote frames on answering and silent transmit objects
   task automatic t_remote();
      cfg(12'h000, 6'h06, 32'hE000_0666, 32'h0000_0048, 32'h6);
      cfg(12'h000, 6'h07, 32'hE000_0777, 32'h0000_0008, 32'h7);
      i_cmh_partner.rx_send({1'b1, 1'b1, 29'h0777, 4'h8, 64'h0});
      apb(1'b0, CMH_OFS_TXRQ, 32'h0);
      chk(rd & 32'h60, 32'h0);
      i_cmh_partner.rx_send({1'b1, 1'b1, 29'h0666, 4'h8, 64'h0});
      wait_load(29'h666);
      apb(1'b1, CMH_OFS_DLO, 32'h6B);
      xfer(12'h000, 6'h06, 8'h87);
      wait_load(29'h666);
      chk(tx_frame.data[31:0], 32'h6B);
      apb(1'b0, 12'hFFC, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task automatic conclude();
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard, far above the several hundred cycles expected
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         conclude();
      end
   end
   initial
   begin
      repeat (5) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      @(posedge i_mclk);
      t_prio();
      t_rx();
      t_remote();
      conclude();
   end
endmodule

/* dv/cmh_partner.sv */
// Behavioural protocol engine facing the handler's bus side
`timescale 1ns/100ps
module cmh_partner
   import cmh_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Bench controls: shifter enable, fail the next frame
   input wire logic i_en,
   input wire logic i_fail_next,
   // Transmit side
   input wire logic i_tx_load,
   output logic o_tx_ready,
   output logic o_tx_done,
   output logic o_tx_fail,
   // Receive side
   output logic o_rx_hdr_valid = 1'b0,
   output logic o_rx_end = 1'b0,
   output cmh_frame_type o_rx_frame = '1
);
   int cnt_r; // Bus time left for the frame in flight
   logic fail_r; // Outcome chosen at load
   // Shifter free only when idle, so a slow bus can be imposed
   assign o_tx_ready = i_en && (cnt_r == 0);
   // Frame takes 40 cycles, then one outcome pulse
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cnt_r <= 0;
         fail_r <= 1'b0;
         o_tx_done <= 1'b0;
         o_tx_fail <= 1'b0;
      end
      else
      begin
         o_tx_done <= (cnt_r == 1) && !fail_r;
         o_tx_fail <= (cnt_r == 1) && fail_r;
         if (i_tx_load)
         begin
            cnt_r <= 40;
            fail_r <= i_fail_next;
         end
         else if (cnt_r > 0)
            cnt_r <= cnt_r - 1;
      end
   end
   // One received frame; header held until the end pulse, then scrambled
   task automatic rx_send(input cmh_frame_type f);
      o_rx_frame <= f;
      o_rx_hdr_valid <= 1'b1;
      @(posedge i_mclk);
      o_rx_hdr_valid <= 1'b0;
      repeat (40) @(posedge i_mclk);
      o_rx_end <= 1'b1;
      @(posedge i_mclk);
      o_rx_end <= 1'b0;
      o_rx_frame <= ~f;
      @(posedge i_mclk);
   endtask
endmodule

/* hw/cmh_handler.sv */
// CAN message object handler with object RAM, two interface sets and APB
`timescale 1ns/100ps
module cmh_handler
   import cmh_pkg::*;
#(
   parameter int NUM_OBJ = CMH_NUM_OBJ
)
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Transmit side of the protocol engine
   input wire logic i_tx_ready,
   input wire logic i_tx_done,
   input wire logic i_tx_fail,
   output logic o_tx_load,
   output cmh_frame_type o_tx_frame,
   // Receive side of the protocol engine
   input wire logic i_rx_hdr_valid,
   input wire logic i_rx_end,
   input wire cmh_frame_type i_rx_frame
);

   // Object memory, one entry per object
   cmh_obj_type obj_r [NUM_OBJ];
   // Interface set registers, index 0 and 1
   logic [7:0] cmsk_r [2];
   cmh_msk_type imsk_r [2];
   cmh_arb_type iarb_r [2];
   cmh_ctl_type ictl_r [2];
   logic [63:0] idat_r [2];
   logic [5:0] ireq_r [2];
   logic ibusy_r [2];
   // Handler state and scan index
   cmh_state_type state_r;
   logic [CMH_IDX_W-1:0] scan_r;
   logic hit_r;
   // Transmission in flight and its object
   logic tx_act_r;
   logic [CMH_IDX_W-1:0] tx_obj_r;
   // Set when software rewrote the in-flight object after its start
   logic tx_fresh_r;
   // Which interface set is being served
   logic ifx_sel_r;
   // APB and transmit output registers
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic tx_load_r;
   cmh_frame_type tx_frame_r;

   // Combinational helpers
   logic [NUM_OBJ-1:0] pend_vec;
   logic [NUM_OBJ-1:0] fresh_vec;
   logic [NUM_OBJ-1:0] irq_vec;
   logic [NUM_OBJ-1:0] txrq_vec;
   logic [CMH_IDX_W-1:0] best_tx;
   logic best_any;
   logic [CMH_IDX_W-1:0] best_irq;
   logic irq_any;
   logic match;
   logic apb_setup;
   logic [11:0] reg_ofs;
   logic sel_if;
   logic if_hit;
   cmh_obj_type scan_obj;

   // Per-object summary vectors
   genvar g;
   generate
      for (g = 0; g < NUM_OBJ; g++)
      begin : g_vec
         assign pend_vec[g] = obj_r[g].arb.object_valid & obj_r[g].ctl.send_request;
         assign fresh_vec[g] = obj_r[g].ctl.fresh_content_flag;
         assign irq_vec[g] = obj_r[g].ctl.irq_pending;
         assign txrq_vec[g] = obj_r[g].ctl.send_request;
      end
   endgenerate

   // Priority encoders: lowest number wins, identifier plays no part
   always_comb
   begin
      best_tx = '0;
      best_any = 1'b0;
      best_irq = '0;
      irq_any = 1'b0;
      for (int k = NUM_OBJ - 1; k >= 0; k--)
      begin
         if (pend_vec[k])
         begin
            best_tx = CMH_IDX_W'(k);
            best_any = 1'b1;
         end
         if (irq_vec[k])
         begin
            best_irq = CMH_IDX_W'(k);
            irq_any = 1'b1;
         end
      end
   end

   // Acceptance compare of the scanned object against the frame header
   always_comb
   begin
      logic [28:0] fid;
      logic [28:0] oid;
      logic [28:0] m;
      fid = '0;
      oid = '0;
      m = '1;
      scan_obj = obj_r[scan_r];
      // Standard frames compare only the 11 upper identifier bits
      fid = i_rx_frame.xtd ? i_rx_frame.id : {i_rx_frame.id[CMH_STD_HI:CMH_STD_LO], 18'h00000};
      oid = scan_obj.arb.xtd ? scan_obj.arb.id
         : {scan_obj.arb.id[CMH_STD_HI:CMH_STD_LO], 18'h00000};
      if (scan_obj.ctl.use_acceptance_mask)
      begin
         m = scan_obj.msk.msk;
      end
      match = scan_obj.arb.object_valid
         & (((fid ^ oid) & m) == 29'h00000000)
         & (scan_obj.ctl.use_acceptance_mask & ~scan_obj.msk.mxtd
            | (i_rx_frame.xtd == scan_obj.arb.xtd));
   end

   // APB decode
   assign apb_setup = i_psel & ~i_penable;
   assign reg_ofs = i_paddr & ~CMH_IF_STRIDE;
   assign sel_if = i_paddr[6];
   assign if_hit = (i_paddr < 12'h080) && (reg_ofs <= CMH_OFS_DHI) && (i_paddr[1:0] == 2'b00);

   // APB slave: no wait state, answer in the first access cycle
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= apb_setup;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
         if (apb_setup)
         begin
            // Unmapped word reads zero and flags an error
            if (if_hit)
            begin
               case (reg_ofs)
                  CMH_OFS_CRQ: prdata_r <= {16'h0000, ibusy_r[sel_if], 9'h000, ireq_r[sel_if]};
                  CMH_OFS_CMSK: prdata_r <= {24'h000000, cmsk_r[sel_if]};
                  CMH_OFS_MSK: prdata_r <= {1'b0, imsk_r[sel_if]};
                  CMH_OFS_ARB: prdata_r <= iarb_r[sel_if];
                  CMH_OFS_MCTL: prdata_r <= {19'h00000, ictl_r[sel_if]};
                  CMH_OFS_DLO: prdata_r <= idat_r[sel_if][31:0];
                  default: prdata_r <= idat_r[sel_if][63:32];
               endcase
            end
            else if (i_paddr == CMH_OFS_FRESH)
               prdata_r <= 32'(fresh_vec);
            else if (i_paddr == CMH_OFS_TXRQ)
               prdata_r <= 32'(txrq_vec);
            else if (i_paddr == CMH_OFS_INTID)
               prdata_r <= irq_any ? 32'(best_irq) + 32'h00000001 : 32'h00000000;
            else if (i_paddr == CMH_OFS_PEND)
               prdata_r <= 32'(irq_vec);
            else
               pslverr_r <= 1'b1;
         end
      end
   end

   // Interface set registers; command request queues a RAM transfer
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int s = 0; s < 2; s++)
         begin
            cmsk_r[s] <= CMH_CMSK_RST;
            imsk_r[s] <= '0;
            iarb_r[s] <= '0;
            ictl_r[s] <= '0;
            idat_r[s] <= '0;
            ireq_r[s] <= '0;
            ibusy_r[s] <= 1'b0;
         end
      end
      else
      begin
         // Read-back from the object RAM into the set being served
         if (state_r == CMH_IFX && !cmsk_r[ifx_sel_r][CMH_CM_WR])
         begin
            if (cmsk_r[ifx_sel_r][CMH_CM_MASK])
               imsk_r[ifx_sel_r] <= obj_r[ireq_r[ifx_sel_r][4:0]].msk;
            if (cmsk_r[ifx_sel_r][CMH_CM_ARB])
               iarb_r[ifx_sel_r] <= obj_r[ireq_r[ifx_sel_r][4:0]].arb;
            if (cmsk_r[ifx_sel_r][CMH_CM_CTRL])
               ictl_r[ifx_sel_r] <= obj_r[ireq_r[ifx_sel_r][4:0]].ctl;
            if (cmsk_r[ifx_sel_r][CMH_CM_DLO])
               idat_r[ifx_sel_r][31:0] <= obj_r[ireq_r[ifx_sel_r][4:0]].data[31:0];
            if (cmsk_r[ifx_sel_r][CMH_CM_DHI])
               idat_r[ifx_sel_r][63:32] <= obj_r[ireq_r[ifx_sel_r][4:0]].data[63:32];
         end
         if (state_r == CMH_IFX)
            ibusy_r[ifx_sel_r] <= 1'b0;
         // Software writes in the access phase; writes to a busy set are dropped
         if (i_psel && i_penable && i_pwrite && pready_r && if_hit && !ibusy_r[sel_if])
         begin
            case (reg_ofs)
               CMH_OFS_CRQ:
               begin
                  // Object numbers 1..32 start a transfer; others are only stored
                  ireq_r[sel_if] <= i_pwdata[5:0];
                  ibusy_r[sel_if] <= (i_pwdata[5:0] != 6'h00) && (i_pwdata[5:0] <= 6'(NUM_OBJ));
                  if (i_pwdata[5:0] != 6'h00)
                     ireq_r[sel_if] <= i_pwdata[5:0] - 6'h01;
               end
               CMH_OFS_CMSK: cmsk_r[sel_if] <= i_pwdata[7:0];
               CMH_OFS_MSK: imsk_r[sel_if] <= i_pwdata[30:0];
               CMH_OFS_ARB: iarb_r[sel_if] <= i_pwdata;
               CMH_OFS_MCTL: ictl_r[sel_if] <= i_pwdata[12:0];
               CMH_OFS_DLO: idat_r[sel_if][31:0] <= i_pwdata;
               default: idat_r[sel_if][63:32] <= i_pwdata;
            endcase
         end
      end
   end

   // Handler sequencer: interface transfers, receive scan, wait for frame end
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_r <= CMH_IDLE;
         scan_r <= '0;
         hit_r <= 1'b0;
         ifx_sel_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            CMH_IDLE:
            begin
               // Receive header first, then interface sets; one transfer at a time
               if (i_rx_hdr_valid)
               begin
                  scan_r <= '0;
                  hit_r <= 1'b0;
                  state_r <= CMH_SCAN;
               end
               else if (ibusy_r[0] || ibusy_r[1])
               begin
                  ifx_sel_r <= ~ibusy_r[0];
                  state_r <= CMH_IFX;
               end
            end
            CMH_SCAN:
            begin
               // Stop on first match or at the last object
               if (match)
                  hit_r <= 1'b1;
               if (match || scan_r == CMH_IDX_W'(NUM_OBJ - 1))
                  state_r <= CMH_ACT;
               else
                  scan_r <= scan_r + 1'b1;
            end
            CMH_ACT:
            begin
               // Wait for end of frame; no hit means nothing to do
               if (i_rx_end || !hit_r)
                  state_r <= CMH_IDLE;
            end
            default:
               state_r <= CMH_IDLE;
         endcase
      end
   end

   // Object RAM writes and transmit tracking
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int k = 0; k < NUM_OBJ; k++)
            obj_r[k] <= '0;
         tx_act_r <= 1'b0;
         tx_obj_r <= '0;
         tx_fresh_r <= 1'b0;
         tx_load_r <= 1'b0;
         tx_frame_r <= '0;
      end
      else
      begin
         tx_load_r <= 1'b0;
         // Transmit end: success or retry
         if (tx_act_r && i_tx_done)
         begin
            tx_act_r <= 1'b0;
            if (!tx_fresh_r)
               obj_r[tx_obj_r].ctl.send_request <= 1'b0;
         end
         else if (tx_act_r && i_tx_fail)
            tx_act_r <= 1'b0; // request kept, rearbitrated next time
         // Start: shifter free, no interface transfer, best object loaded
         if (!tx_act_r && i_tx_ready && best_any && state_r != CMH_IFX && !tx_load_r)
         begin
            tx_load_r <= 1'b1;
            tx_act_r <= 1'b1;
            tx_obj_r <= best_tx;
            tx_fresh_r <= 1'b0;
            obj_r[best_tx].ctl.fresh_content_flag <= 1'b0;
            tx_frame_r.xtd <= obj_r[best_tx].arb.xtd;
            tx_frame_r.rtr <= ~obj_r[best_tx].arb.dir;
            tx_frame_r.id <= obj_r[best_tx].arb.xtd ? obj_r[best_tx].arb.id
               : {obj_r[best_tx].arb.id[CMH_STD_HI:CMH_STD_LO], 18'h00000};
            tx_frame_r.dlc <= obj_r[best_tx].ctl.dlc;
            tx_frame_r.data <= obj_r[best_tx].data;
         end
         // Interface set transfer, atomic in one cycle
         if (state_r == CMH_IFX)
         begin
            if (cmsk_r[ifx_sel_r][CMH_CM_WR])
            begin
               if (cmsk_r[ifx_sel_r][CMH_CM_MASK])
                  obj_r[ireq_r[ifx_sel_r][4:0]].msk <= imsk_r[ifx_sel_r];
               if (cmsk_r[ifx_sel_r][CMH_CM_ARB])
                  obj_r[ireq_r[ifx_sel_r][4:0]].arb <= iarb_r[ifx_sel_r];
               if (cmsk_r[ifx_sel_r][CMH_CM_CTRL])
                  obj_r[ireq_r[ifx_sel_r][4:0]].ctl <= ictl_r[ifx_sel_r];
               if (cmsk_r[ifx_sel_r][CMH_CM_DLO])
                  obj_r[ireq_r[ifx_sel_r][4:0]].data[31:0] <= idat_r[ifx_sel_r][31:0];
               if (cmsk_r[ifx_sel_r][CMH_CM_DHI])
                  obj_r[ireq_r[ifx_sel_r][4:0]].data[63:32] <= idat_r[ifx_sel_r][63:32];
               // Data-only update: fresh select sets request together
               if (cmsk_r[ifx_sel_r][CMH_CM_FRESH])
               begin
                  obj_r[ireq_r[ifx_sel_r][4:0]].ctl.send_request <= 1'b1;
                  obj_r[ireq_r[ifx_sel_r][4:0]].ctl.fresh_content_flag <= 1'b1;
               end
               // A rewrite of the in-flight object keeps its request alive
               if (tx_act_r && tx_obj_r == ireq_r[ifx_sel_r][4:0])
                  tx_fresh_r <= 1'b1;
            end
            else
            begin
               // Read with clear selects: acknowledge fresh and pending
               if (cmsk_r[ifx_sel_r][CMH_CM_FRESH])
                  obj_r[ireq_r[ifx_sel_r][4:0]].ctl.fresh_content_flag <= 1'b0;
               if (cmsk_r[ifx_sel_r][CMH_CM_CLRINT])
                  obj_r[ireq_r[ifx_sel_r][4:0]].ctl.irq_pending <= 1'b0;
            end
         end
         // Success set sits after any interface clear of this cycle, so the set wins
         if (tx_act_r && i_tx_done && obj_r[tx_obj_r].ctl.send_irq_enable)
            obj_r[tx_obj_r].ctl.irq_pending <= 1'b1;
         // Receive action at frame end on the matched object
         if (state_r == CMH_ACT && hit_r && i_rx_end)
         begin
            if (!i_rx_frame.rtr)
            begin
               // Data frame: store all, mark fresh, lost if overrun
               obj_r[scan_r].data <= i_rx_frame.data;
               obj_r[scan_r].arb.id <= i_rx_frame.xtd ? i_rx_frame.id
                  : {i_rx_frame.id[CMH_STD_HI:CMH_STD_LO], 18'h00000};
               obj_r[scan_r].arb.xtd <= i_rx_frame.xtd;
               obj_r[scan_r].ctl.dlc <= i_rx_frame.dlc;
               obj_r[scan_r].ctl.fresh_content_flag <= 1'b1;
               obj_r[scan_r].ctl.send_request <= 1'b0;
               if (obj_r[scan_r].ctl.fresh_content_flag)
                  obj_r[scan_r].ctl.overrun_lost_flag <= 1'b1;
               if (obj_r[scan_r].ctl.receive_irq_enable)
                  obj_r[scan_r].ctl.irq_pending <= 1'b1;
            end
            else if (obj_r[scan_r].arb.dir && obj_r[scan_r].ctl.remote_answer_enable)
               obj_r[scan_r].ctl.send_request <= 1'b1;
            else if (obj_r[scan_r].arb.dir && obj_r[scan_r].ctl.use_acceptance_mask)
            begin
               // Header stored, data kept, software answers by hand
               obj_r[scan_r].ctl.send_request <= 1'b0;
               obj_r[scan_r].arb.id <= i_rx_frame.id;
               obj_r[scan_r].arb.xtd <= i_rx_frame.xtd;
               obj_r[scan_r].ctl.dlc <= i_rx_frame.dlc;
               obj_r[scan_r].ctl.fresh_content_flag <= 1'b1;
            end
            // Remaining remote case leaves the object alone
         end
      end
   end

   // Output drive
   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_tx_load = tx_load_r;
   assign o_tx_frame = tx_frame_r;

endmodule

/* hw/cmh_pkg.sv */
// Package for the CAN message object handler: map, fields, states, carriers
package cmh_pkg;
   // Object count and index width
   localparam int CMH_NUM_OBJ = 32;
   localparam int CMH_IDX_W = 5;
   // Register byte offsets, one aligned word each, two interface sets
   localparam logic [11:0] CMH_IF_STRIDE = 12'h040;
   localparam logic [11:0] CMH_OFS_CRQ = 12'h000;
   localparam logic [11:0] CMH_OFS_CMSK = 12'h004;
   localparam logic [11:0] CMH_OFS_MSK = 12'h008;
   localparam logic [11:0] CMH_OFS_ARB = 12'h00C;
   localparam logic [11:0] CMH_OFS_MCTL = 12'h010;
   localparam logic [11:0] CMH_OFS_DLO = 12'h014;
   localparam logic [11:0] CMH_OFS_DHI = 12'h018;
   localparam logic [11:0] CMH_OFS_FRESH = 12'h080;
   localparam logic [11:0] CMH_OFS_TXRQ = 12'h084;
   localparam logic [11:0] CMH_OFS_INTID = 12'h088;
   localparam logic [11:0] CMH_OFS_PEND = 12'h08C;
   // Command mask bit positions
   localparam int CMH_CM_WR = 7;
   localparam int CMH_CM_MASK = 6;
   localparam int CMH_CM_ARB = 5;
   localparam int CMH_CM_CTRL = 4;
   localparam int CMH_CM_CLRINT = 3;
   localparam int CMH_CM_FRESH = 2;
   localparam int CMH_CM_DLO = 1;
   localparam int CMH_CM_DHI = 0;
   // Command request busy bit position
   localparam int CMH_CRQ_BUSY = 15;
   // Standard identifier field position inside the 29-bit identifier
   localparam int CMH_STD_HI = 28;
   localparam int CMH_STD_LO = 18;
   // Reset values
   localparam logic [7:0] CMH_CMSK_RST = 8'h00;
   // Control word of one object
   typedef struct packed {
      logic fresh_content_flag;
      logic overrun_lost_flag;
      logic irq_pending;
      logic use_acceptance_mask;
      logic send_irq_enable;
      logic receive_irq_enable;
      logic remote_answer_enable;
      logic send_request;
      logic end_of_buffer;
      logic [3:0] dlc;
   } cmh_ctl_type;
   // Arbitration word of one object
   typedef struct packed {
      logic object_valid;
      logic xtd;
      logic dir;
      logic [28:0] id;
   } cmh_arb_type;
   // Mask word of one object
   typedef struct packed {
      logic mxtd;
      logic mdir;
      logic [28:0] msk;
   } cmh_msk_type;
   // One whole message object
   typedef struct packed {
      cmh_msk_type msk;
      cmh_arb_type arb;
      cmh_ctl_type ctl;
      logic [63:0] data;
   } cmh_obj_type;
   // Frame header and payload exchanged with the protocol engine, both directions
   typedef struct packed {
      logic xtd;
      logic rtr;
      logic [28:0] id;
      logic [3:0] dlc;
      logic [63:0] data;
   } cmh_frame_type;
   // Handler states, Gray along idle, scan, act
   typedef enum logic [1:0]
   {
      CMH_IDLE = 2'b00,
      CMH_SCAN = 2'b01,
      CMH_ACT = 2'b11,
      CMH_IFX = 2'b10
   } cmh_state_type;
endpackage
